//--- rtl/tcc_pkg.sv
// Package with register map, field positions and reset values of the capture/compare timer.
package tcc_pkg;

    // Register byte offsets.
    localparam logic [7:0] TCC_OFS_TCTL = 8'h00;
    localparam logic [7:0] TCC_OFS_COUNT = 8'h04;
    localparam logic [7:0] TCC_OFS_MODULO = 8'h08;
    localparam logic [7:0] TCC_OFS_CH0_CTL = 8'h0c;
    localparam logic [7:0] TCC_OFS_CH0_VAL = 8'h10;
    localparam logic [7:0] TCC_OFS_CH_STEP = 8'h08;

    // Timer control register fields.
    localparam int TCC_TCTL_OVF = 7;
    localparam int TCC_TCTL_OVIE = 6;
    localparam int TCC_TCTL_HALT = 5;
    localparam int TCC_TCTL_CRST = 4;
    localparam int TCC_TCTL_PS = 0;

    // Channel control register fields.
    localparam int TCC_CH_FLAG = 7;
    localparam int TCC_CH_IE = 6;
    localparam int TCC_CH_MSB = 5;
    localparam int TCC_CH_MSA = 4;
    localparam int TCC_CH_ELSH = 3;
    localparam int TCC_CH_ELSL = 2;
    localparam int TCC_CH_TOGW = 1;
    localparam int TCC_CH_MAX = 0;

    // Values after reset.
    localparam logic [15:0] TCC_MODULO_RST = 16'hffff;
    localparam logic [7:0] TCC_CHCTL_RST = 8'h00;
    localparam logic [2:0] TCC_PS_RST = 3'h0;
    localparam logic TCC_HALT_RST = 1'b0;

    // Largest prescale select that gives a distinct rate.
    localparam logic [2:0] TCC_PS_TOP = 3'h6;
    localparam int TCC_PRESC_W = 6;

    // Output compare pin actions.
    localparam logic [1:0] TCC_ACT_TOGGLE = 2'h1;
    localparam logic [1:0] TCC_ACT_CLEAR = 2'h2;
    localparam logic [1:0] TCC_ACT_SET = 2'h3;

    typedef enum logic {TCC_BUS_IDLE, TCC_BUS_ACCESS} tcc_bus_state_type;

endpackage

//--- rtl/tcc_timer.sv
// Two-channel capture/compare timer with an AHB-Lite register slave.
//
// Functional notes
// - One 16-bit up-counter is the shared time base, free-running or modulo.
// - Wrap value comes from the software-written 16-bit modulo register.
// - Counter reads never stall, reset or disturb counting.
// - Two channels, each independently input capture or output compare.
// - Prescaler gives seven rates from the bus clock, chosen by 3-bit select.
// - Capture edge chosen by two edge bits: rising, falling or either.
// - Active capture edge copies the counter into the channel value register.
// - Every qualifying edge captures regardless of flag; flag requests interrupt if enabled.
// - Captured value appears a fixed short delay after the pin edge.
// - A later capture overwrites the earlier value.
// - Reset leaves channel value registers untouched.
// - Compare match sets, clears or toggles the pin as configured.
// - Capture and compare events set the flag; enabled flag raises interrupt.
// - Unbuffered compare uses the live value; a passed value gives no match.
// - Link bit in channel 0 joins both channels into one buffered output on pin 0.
// - Linked: channel 0 controls first, then the last-written pair from each overflow.
// - Linked: channel 0 control governs; channel 1 control unused, pin 1 freed.
// - Toggle-on-overflow toggles the pin at wrap; overflow spacing is the period.
// - Period spans modulo plus one counts; 00ff at rate one gives 256 clocks.
// - Overflow flag sets as the counter wraps from modulo to zero; enabled flag requests interrupt.
// - Toggle-on-overflow cleared stops overflow toggles, compares then hold the level.
// - Counter reset bit clears counter and prescaler; halt bit stops counting.
`timescale 1ns/10ps
`default_nettype none

module tcc_timer
    import tcc_pkg::*;
#(
    parameter int NUM_CHAN = 2
) (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RST_N,
    // AHB-Lite slave.
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Channel pins.
    input wire logic [1:0] CHAN_PIN_IN,
    output logic [1:0] CHAN_PIN_OUT,
    output logic [1:0] CHAN_PIN_OE,
    // Interrupt requests.
    output logic [1:0] CHAN_IRQ_REQ,
    output logic OVF_IRQ_REQ
);

    if (NUM_CHAN != 2) begin : g_chan_check
        $error("tcc_timer supports exactly two channels");
    end

    // Byte offset of a channel register, base plus one step per channel.
    function automatic logic [7:0] ch_ofs(input logic [7:0] base, input int idx);
        ch_ofs = base + (idx[0] ? TCC_OFS_CH_STEP : 8'h00);
    endfunction

    // Prescaler tick for a select value; selects above the top rate reuse it.
    function automatic logic presc_tick(input logic [5:0] presc, input logic [2:0] sel);
        logic [2:0] s;
        logic [6:0] m7;
        s = (sel > TCC_PS_TOP) ? TCC_PS_TOP : sel;
        m7 = (7'h01 << s) - 7'h01;
        presc_tick = ((presc & m7[5:0]) == m7[5:0]);
    endfunction

    // ---------------- Bus slave ----------------
    tcc_bus_state_type bus_state_ff;
    logic [7:0] addr_ff;
    logic write_ff;
    logic [31:0] hrdata_ff;
    wire addr_ok = HSEL & HTRANS[1] & HREADY;
    wire access = (bus_state_ff == TCC_BUS_ACCESS);
    wire wr_en = access & write_ff;
    wire rd_en = access & ~write_ff;
    wire wr_tctl = wr_en & (addr_ff == TCC_OFS_TCTL);
    wire wr_mod = wr_en & (addr_ff == TCC_OFS_MODULO);

    // One wait state lets a read see writes made by the previous transfer.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            bus_state_ff <= TCC_BUS_IDLE;
            addr_ff <= 8'h00;
            write_ff <= 1'b0;
        end else begin
            bus_state_ff <= addr_ok ? TCC_BUS_ACCESS : TCC_BUS_IDLE;
            if (addr_ok) begin
                addr_ff <= {HADDR[7:2], 2'b00};
                write_ff <= HWRITE;
            end
        end
    end

    assign HREADYOUT = ~access;
    assign HRESP = 1'b0;
    assign HRDATA = hrdata_ff;

    // ---------------- Timer control and counter ----------------
    logic [15:0] cnt_ff;
    logic [5:0] presc_ff;
    logic [15:0] mod_ff;
    logic ovf_ff;
    logic ovie_ff;
    logic halt_ff;
    logic [2:0] ps_ff;
    logic nxt_ovf;

    wire crst = wr_tctl & HWDATA[TCC_TCTL_CRST];
    wire tick = ~halt_ff & presc_tick(presc_ff, ps_ff);
    wire wrap = tick & (cnt_ff == mod_ff);
    wire [15:0] cnt_next = wrap ? 16'h0000 : cnt_ff + 16'h0001;
    wire ovf_clr = wr_tctl & ~HWDATA[TCC_TCTL_OVF];

    assign nxt_ovf = wrap | (ovf_ff & ~ovf_clr);

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_ff <= 16'h0000;
            presc_ff <= 6'h00;
        end else if (crst) begin
            cnt_ff <= 16'h0000;
            presc_ff <= 6'h00;
        end else begin
            if (tick) begin
                cnt_ff <= cnt_next;
            end
            if (!halt_ff) begin
                presc_ff <= presc_ff + 6'h01;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ovf_ff <= 1'b0;
            ovie_ff <= 1'b0;
            halt_ff <= TCC_HALT_RST;
            ps_ff <= TCC_PS_RST;
            mod_ff <= TCC_MODULO_RST;
        end else begin
            ovf_ff <= nxt_ovf;
            if (wr_tctl) begin
                ovie_ff <= HWDATA[TCC_TCTL_OVIE];
                halt_ff <= HWDATA[TCC_TCTL_HALT];
                ps_ff <= HWDATA[TCC_TCTL_PS +: 3];
            end
            if (wr_mod) begin
                mod_ff <= HWDATA[15:0];
            end
        end
    end

    assign OVF_IRQ_REQ = ovf_ff & ovie_ff;

    // ---------------- Channels ----------------
    logic [7:0] chctl_ff [NUM_CHAN];
    logic [7:0] nxt_chctl [NUM_CHAN];
    logic [15:0] val_ff [NUM_CHAN];
    logic [1:0] sync1_ff;
    logic [1:0] sync2_ff;
    logic [1:0] sync3_ff;
    logic [1:0] lvl_ff;
    logic [1:0] pin_ff;
    logic active_ff;
    logic last_wr_ff;
    logic [1:0] wr_ctl;
    logic [1:0] wr_val;
    logic [1:0] is_ic;
    logic [1:0] is_oc;
    logic [1:0] ic_edge;
    logic [1:0] cmp;
    logic [1:0] els [NUM_CHAN];
    logic [15:0] cmp_val [NUM_CHAN];

    wire linked = chctl_ff[0][TCC_CH_MSB];

    for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
        // Channel 1 is out of service while linked.
        wire ch_on = (i == 0) | ~linked;
        wire msb = chctl_ff[i][TCC_CH_MSB];
        wire msa = chctl_ff[i][TCC_CH_MSA];
        assign wr_ctl[i] = wr_en & (addr_ff == ch_ofs(TCC_OFS_CH0_CTL, i));
        assign wr_val[i] = wr_en & (addr_ff == ch_ofs(TCC_OFS_CH0_VAL, i));
        assign els[i] = chctl_ff[i][TCC_CH_ELSL +: 2];
        assign is_ic[i] = ch_on & ~msb & ~msa;
        assign is_oc[i] = ch_on & (msb | msa);
        // An edge counts once the two late synchroniser stages agree.
        assign ic_edge[i] = is_ic[i] & (sync2_ff[i] == sync3_ff[i])
            & (sync3_ff[i] != lvl_ff[i])
            & ((sync3_ff[i] & els[i][0]) | (~sync3_ff[i] & els[i][1]));
        // Linked channel 0 compares against whichever pair is active.
        assign cmp_val[i] = ((i == 0) & linked) ? val_ff[active_ff] : val_ff[i];
        // A value already passed never matches until the counter comes round.
        assign cmp[i] = is_oc[i] & tick & (cnt_next == cmp_val[i]);
    end

    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            nxt_chctl[i] = wr_ctl[i] ? HWDATA[7:0] : chctl_ff[i];
            nxt_chctl[i][TCC_CH_FLAG] = ic_edge[i] | cmp[i]
                | (chctl_ff[i][TCC_CH_FLAG] & ~(wr_ctl[i] & ~HWDATA[TCC_CH_FLAG]));
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_ff <= 2'h0;
            sync2_ff <= 2'h0;
            sync3_ff <= 2'h0;
            lvl_ff <= 2'h0;
        end else begin
            sync1_ff <= CHAN_PIN_IN;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (sync2_ff[i] == sync3_ff[i]) begin
                    lvl_ff[i] <= sync3_ff[i];
                end
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                chctl_ff[i] <= TCC_CHCTL_RST;
            end
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                chctl_ff[i] <= nxt_chctl[i];
            end
        end
    end

    // No reset here: captured and compare values survive a system reset.
    always_ff @(posedge REF_CLK) begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (ic_edge[i]) begin
                val_ff[i] <= cnt_ff;
            end else if (wr_val[i]) begin
                val_ff[i] <= HWDATA[15:0];
            end
        end
    end

    // Buffer selection for the linked pair.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            active_ff <= 1'b0;
            last_wr_ff <= 1'b0;
        end else if (!linked) begin
            active_ff <= 1'b0;
            last_wr_ff <= 1'b0;
        end else begin
            if (wr_val[1]) begin
                last_wr_ff <= 1'b1;
            end else if (wr_val[0]) begin
                last_wr_ff <= 1'b0;
            end
            if (wrap) begin
                active_ff <= last_wr_ff;
            end
        end
    end

    // Pin drive: overflow toggle outranks a compare in the same cycle.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_ff <= 2'h0;
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (is_oc[i] & wrap & chctl_ff[i][TCC_CH_TOGW]) begin
                    if (chctl_ff[i][TCC_CH_MAX]) begin
                        pin_ff[i] <= 1'b1;
                    end else begin
                        pin_ff[i] <= ~pin_ff[i];
                    end
                end else if (cmp[i] & ~(chctl_ff[i][TCC_CH_TOGW] & chctl_ff[i][TCC_CH_MAX])) begin
                    // Set or clear onto the held level is a no-op, giving 100 % duty for set and 0 % for clear.
                    case (els[i])
                        TCC_ACT_TOGGLE: pin_ff[i] <= ~pin_ff[i];
                        TCC_ACT_CLEAR: pin_ff[i] <= 1'b0;
                        TCC_ACT_SET: pin_ff[i] <= 1'b1;
                        default: pin_ff[i] <= pin_ff[i];
                    endcase
                end
            end
        end
    end

    for (genvar i = 0; i < NUM_CHAN; i++) begin : g_pin
        assign CHAN_PIN_OE[i] = is_oc[i] & (els[i] != 2'h0);
        assign CHAN_PIN_OUT[i] = pin_ff[i];
        assign CHAN_IRQ_REQ[i] = chctl_ff[i][TCC_CH_FLAG] & chctl_ff[i][TCC_CH_IE];
    end

    // ---------------- Read data ----------------
    wire [31:0] rd_tctl = (32'(ovf_ff) << TCC_TCTL_OVF) | (32'(ovie_ff) << TCC_TCTL_OVIE)
        | (32'(halt_ff) << TCC_TCTL_HALT) | (32'(ps_ff) << TCC_TCTL_PS);
    wire [31:0] rd_mux =
        (addr_ff == TCC_OFS_TCTL) ? rd_tctl :
        (addr_ff == TCC_OFS_COUNT) ? {16'h0000, cnt_ff} :
        (addr_ff == TCC_OFS_MODULO) ? {16'h0000, mod_ff} :
        (addr_ff == ch_ofs(TCC_OFS_CH0_CTL, 0)) ? {24'h000000, chctl_ff[0]} :
        (addr_ff == ch_ofs(TCC_OFS_CH0_VAL, 0)) ? {16'h0000, val_ff[0]} :
        (addr_ff == ch_ofs(TCC_OFS_CH0_CTL, 1)) ? {24'h000000, chctl_ff[1]} :
        (addr_ff == ch_ofs(TCC_OFS_CH0_VAL, 1)) ? {16'h0000, val_ff[1]} :
        32'h00000000;

    // Reading the count only samples it; the counter path has no read term.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            hrdata_ff <= 32'h00000000;
        end else if (rd_en) begin
            hrdata_ff <= rd_mux;
        end
    end

    // ---------------- Assertions ----------------
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    sequence cleared_s;
        (cnt_ff == 16'h0000) && (presc_ff == 6'h00);
    endsequence

    sequence wrapped_s;
        (cnt_ff == 16'h0000) ##0 ovf_ff;
    endsequence

    ovf_flag_set_a: assert property (wrap |=> wrapped_s)
        else $error("overflow flag or wrap missing after modulo");
    cnt_step_a: assert property (tick && !wrap && !crst |=> cnt_ff == $past(cnt_ff) + 16'h0001)
        else $error("counter did not advance by one");
    cnt_clear_a: assert property (crst |=> cleared_s)
        else $error("counter reset did not clear counter and prescaler");
    read_quiet_a: assert property (rd_en && !tick && !crst |=> $stable(cnt_ff))
        else $error("counter moved on a read");
    halt_hold_a: assert property (halt_ff && !crst |=> $stable(cnt_ff))
        else $error("counter moved while halted");
    capture_value_a: assert property (ic_edge[0] |=> val_ff[0] == $past(cnt_ff))
        else $error("capture did not load counter value");
    capture_flag_a: assert property (ic_edge[0] |=> chctl_ff[0][TCC_CH_FLAG])
        else $error("capture did not set channel flag");
    compare_set_a: assert property (cmp[1] && els[1] == TCC_ACT_SET
        && !(chctl_ff[1][TCC_CH_TOGW] && (wrap || chctl_ff[1][TCC_CH_MAX]))
        |=> CHAN_PIN_OUT[1])
        else $error("set on compare did not raise pin");
    wrap_toggle_a: assert property (wrap && is_oc[0] && chctl_ff[0][TCC_CH_TOGW]
        && !chctl_ff[0][TCC_CH_MAX] |=> CHAN_PIN_OUT[0] != $past(CHAN_PIN_OUT[0]))
        else $error("pin did not toggle on overflow");
    link_start_a: assert property ($rose(linked) |-> ##1 !active_ff ##1 !active_ff)
        else $error("linked pair did not start on channel 0");
    link_free_a: assert property (linked |-> !CHAN_PIN_OE[1] && !cmp[1])
        else $error("channel 1 still active while linked");
    ps_rate_a: assert property ((!halt_ff && ps_ff == 3'h1 && tick && !wr_tctl)
        ##1 !wr_tctl |-> !tick ##1 tick)
        else $error("divide by two rate wrong");

endmodule

`default_nettype wire

//--- verif/tcc_pin_load.sv
// External signal source and load on the two timer channel pins.
`timescale 1ns/10ps
`default_nettype none

module tcc_pin_load (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Pin side of the timer.
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    input wire logic [1:0] src_level,
    output logic [1:0] pin_lvl,
    // Measurements on pin 0.
    output logic [31:0] period,
    output logic [31:0] high_time,
    output logic [31:0] rises
);
    logic [31:0] cyc_ff;
    logic [31:0] rise_ff;
    logic prev_ff;

    // The source drives only a pin that the timer leaves free, so no contention.
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & src_level);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_ff <= 32'h0;
            rise_ff <= 32'h0;
            prev_ff <= 1'b0;
            period <= 32'h0;
            high_time <= 32'h0;
            rises <= 32'h0;
        end else begin
            cyc_ff <= cyc_ff + 32'h1;
            prev_ff <= pin_lvl[0];
            if (pin_lvl[0] && !prev_ff) begin
                period <= cyc_ff - rise_ff;
                rise_ff <= cyc_ff;
                rises <= rises + 32'h1;
            end
            if (!pin_lvl[0] && prev_ff) begin
                high_time <= cyc_ff - rise_ff;
            end
        end
    end
endmodule

`default_nettype wire

//--- verif/tb_top.sv
// Self-checking testbench of the capture/compare timer.
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import tcc_pkg::*;
;
    localparam logic [7:0] CH1_CTL = TCC_OFS_CH0_CTL + TCC_OFS_CH_STEP;
    localparam logic [7:0] CH1_VAL = TCC_OFS_CH0_VAL + TCC_OFS_CH_STEP;
    logic REF_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic HSEL = 1'b0;
    logic HWRITE = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [31:0] HWDATA = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic [2:0] HSIZE = 3'h2;
    logic HREADY;
    logic HRESP;
    logic [31:0] HRDATA;
    logic [1:0] CHAN_PIN_IN;
    logic [1:0] CHAN_PIN_OUT;
    logic [1:0] CHAN_PIN_OE;
    logic [1:0] CHAN_IRQ_REQ;
    logic OVF_IRQ_REQ;
    logic [1:0] src = 2'h0;
    logic [31:0] per_meas, hi_meas, rise_cnt, rd, v, last, m;
    logic [1:0] sel;
    logic p;
    logic [1:0] acts [3] = '{TCC_ACT_SET, TCC_ACT_CLEAR, TCC_ACT_TOGGLE};
    int err_count = 0;
    int n_compared = 0;

    tcc_timer dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
        .HRDATA(HRDATA), .HREADYOUT(HREADY), .HRESP(HRESP), .CHAN_PIN_IN(CHAN_PIN_IN),
        .CHAN_PIN_OUT(CHAN_PIN_OUT), .CHAN_PIN_OE(CHAN_PIN_OE),
        .CHAN_IRQ_REQ(CHAN_IRQ_REQ), .OVF_IRQ_REQ(OVF_IRQ_REQ));

    tcc_pin_load load (.clk(REF_CLK), .rst_n(RST_N), .pin_out(CHAN_PIN_OUT),
        .pin_oe(CHAN_PIN_OE), .src_level(src), .pin_lvl(CHAN_PIN_IN), .period(per_meas),
        .high_time(hi_meas), .rises(rise_cnt));

    always #10 REF_CLK = ~REF_CLK;

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    // Entered right after a rising edge; returns at the edge that ends the data phase.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        @(posedge REF_CLK iff HREADY === 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        @(posedge REF_CLK iff HREADY === 1'b1);
        rd = HRDATA;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdv(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic idle(input logic [31:0] n);
        repeat (n) @(posedge REF_CLK);
    endtask

    function automatic logic [31:0] tctl(input logic ie, input logic halt, input logic crst,
                                         input logic [2:0] ps);
        return (32'(ie) << TCC_TCTL_OVIE) | (32'(halt) << TCC_TCTL_HALT)
            | (32'(crst) << TCC_TCTL_CRST) | (32'(ps) << TCC_TCTL_PS);
    endfunction

    function automatic logic [31:0] chctl(input logic ie, input logic [1:0] mode,
                                          input logic [1:0] el, input logic tov);
        return (32'(ie) << TCC_CH_IE) | (32'(mode) << TCC_CH_MSA)
            | (32'(el) << TCC_CH_ELSL) | (32'(tov) << TCC_CH_TOGW);
    endfunction

    function automatic logic exp_pin(input logic [1:0] act, input logic prev);
        return (act == TCC_ACT_TOGGLE) ? ~prev : (act == TCC_ACT_SET);
    endfunction

    function automatic logic [31:0] period(input logic [15:0] mod, input logic [2:0] ps);
        return (32'(mod) + 32'h1) << ps;
    endfunction

    task automatic pwm(input logic [15:0] mod, input logic [15:0] val, input logic [2:0] ps);
        wr(TCC_OFS_TCTL, tctl(1'b0, 1'b1, 1'b1, ps));
        wr(TCC_OFS_MODULO, {16'h0, mod});
        wr(TCC_OFS_CH0_VAL, {16'h0, val});
        wr(TCC_OFS_CH0_CTL, chctl(1'b0, 2'h1, TCC_ACT_CLEAR, 1'b1));
        wr(TCC_OFS_TCTL, tctl(1'b0, 1'b0, 1'b0, ps));
        idle(3 * period(mod, ps));
        chk(per_meas, period(mod, ps));
        chk(hi_meas, 32'(val) << ps);
    endtask

    initial begin
        repeat (60000) @(posedge REF_CLK);
        err_count++;
        end_of_test;
    end

    initial begin
        void'($urandom(50188));
        idle(10);
        RST_N <= 1'b1;
        @(posedge REF_CLK);
        rdv(TCC_OFS_MODULO);
        chk(rd, {16'h0, TCC_MODULO_RST});
        rdv(TCC_OFS_CH0_CTL);
        chk(rd, {24'h0, TCC_CHCTL_RST});
        rdv(8'h3c);
        chk(rd, 32'h0);
        wr(TCC_OFS_TCTL, tctl(1'b0, 1'b1, 1'b1, 3'h0));
        rdv(TCC_OFS_COUNT);
        chk(rd, 32'h0);
        chk_bit(HRESP, 1'b0);
        wr(TCC_OFS_TCTL, tctl(1'b0, 1'b0, 1'b0, 3'h0));
        rdv(TCC_OFS_COUNT);
        v = rd;
        rdv(TCC_OFS_COUNT);
        chk(rd, v + 32'h3);
        $display("test counter done");
        m = 32'($urandom_range(40, 16));
        wr(TCC_OFS_TCTL, tctl(1'b1, 1'b1, 1'b1, 3'h0));
        wr(TCC_OFS_MODULO, m);
        wr(TCC_OFS_TCTL, tctl(1'b1, 1'b0, 1'b0, 3'h0));
        idle(m - 32'h4);
        chk_bit(OVF_IRQ_REQ, 1'b0);
        idle(32'h8);
        chk_bit(OVF_IRQ_REQ, 1'b1);
        rdv(TCC_OFS_COUNT);
        chk_bit(rd <= m, 1'b1);
        $display("test overflow done");
        wr(TCC_OFS_MODULO, 32'hffff);
        for (int s = 1; s < 4; s++) begin
            for (int e = 0; e < 2; e++) begin
                sel = 2'(s);
                wr(TCC_OFS_CH0_CTL, chctl(1'b1, 2'h0, sel, 1'b0));
                wr(TCC_OFS_TCTL, tctl(1'b0, 1'b0, 1'b0, 3'h0));
                idle(32'($urandom_range(9, 1)));
                wr(TCC_OFS_TCTL, tctl(1'b0, 1'b1, 1'b0, 3'h0));
                rdv(TCC_OFS_COUNT);
                v = rd;
                src[0] <= ~src[0];
                idle(32'h6);
                chk_bit(CHAN_IRQ_REQ[0], sel[e]);
                rdv(TCC_OFS_CH0_CTL);
                chk_bit(rd[TCC_CH_FLAG], sel[e]);
                if (sel[e]) begin
                    last = v;
                end
                rdv(TCC_OFS_CH0_VAL);
                chk(rd, last);
            end
        end
        $display("test capture done");
        RST_N <= 1'b0;
        idle(32'h3);
        RST_N <= 1'b1;
        @(posedge REF_CLK);
        rdv(TCC_OFS_CH0_VAL);
        chk(rd, last);
        $display("test reset keeps value done");
        wr(TCC_OFS_MODULO, 32'h3f);
        p = 1'b0;
        for (int i = 0; i < 3; i++) begin
            v = 32'($urandom_range(30, 8));
            wr(TCC_OFS_TCTL, tctl(1'b0, 1'b1, 1'b1, 3'h0));
            wr(CH1_VAL, v);
            wr(CH1_CTL, chctl(1'b1, 2'h1, acts[i], 1'b0));
            wr(TCC_OFS_TCTL, tctl(1'b0, 1'b0, 1'b0, 3'h0));
            idle(v);
            wr(TCC_OFS_TCTL, tctl(1'b0, 1'b1, 1'b0, 3'h0));
            p = exp_pin(acts[i], p);
            chk_bit(CHAN_PIN_OUT[1], p);
            chk_bit(CHAN_PIN_OE[1], 1'b1);
            chk_bit(CHAN_IRQ_REQ[1], 1'b1);
        end
        // A smaller value written once the compare has fired must not match again.
        wr(CH1_VAL, 32'h2);
        wr(CH1_CTL, chctl(1'b1, 2'h1, TCC_ACT_SET, 1'b0));
        wr(TCC_OFS_TCTL, tctl(1'b0, 1'b0, 1'b0, 3'h0));
        idle(32'h14);
        wr(TCC_OFS_TCTL, tctl(1'b0, 1'b1, 1'b0, 3'h0));
        chk_bit(CHAN_IRQ_REQ[1], 1'b0);
        $display("test compare done");
        pwm(16'h00ff, 16'h0080, 3'h0);
        for (int ps = 0; ps < 7; ps++) begin
            pwm(16'h000f, 16'($urandom_range(14, 1)), 3'(ps));
        end
        wr(TCC_OFS_CH0_CTL, chctl(1'b0, 2'h1, TCC_ACT_CLEAR, 1'b0));
        idle(period(16'h000f, 3'h6));
        v = rise_cnt;
        idle(3 * period(16'h000f, 3'h6));
        chk(rise_cnt, v);
        // Maximum duty with toggle on wrap holds the pin high, so no further rising edges.
        wr(TCC_OFS_CH0_CTL, chctl(1'b0, 2'h1, TCC_ACT_CLEAR, 1'b1) | (32'h1 << TCC_CH_MAX));
        idle(period(16'h000f, 3'h6));
        v = rise_cnt;
        idle(2 * period(16'h000f, 3'h6));
        chk(rise_cnt, v);
        chk_bit(CHAN_PIN_OUT[0], 1'b1);
        $display("test pwm done");
        m = 32'($urandom_range(24, 8));
        v = 32'($urandom_range(56, 32));
        wr(TCC_OFS_TCTL, tctl(1'b0, 1'b1, 1'b1, 3'h0));
        wr(TCC_OFS_MODULO, 32'h3f);
        wr(TCC_OFS_CH0_VAL, m);
        wr(TCC_OFS_CH0_CTL, chctl(1'b0, 2'h2, TCC_ACT_CLEAR, 1'b1));
        wr(TCC_OFS_TCTL, tctl(1'b0, 1'b0, 1'b0, 3'h0));
        idle(32'hc0);
        chk(hi_meas, m);
        chk_bit(CHAN_PIN_OE[1], 1'b0);
        wr(CH1_VAL, v);
        idle(32'hc0);
        chk(hi_meas, v);
        $display("test linked done");
        end_of_test;
    end
endmodule

`default_nettype wire
